// ---- hdl/tsr_defines.svh ----
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// Width of each half of the captured word
`define TSR_HALF_W 32
// Width of one captured timestamp word
`define TSR_WORD_W 64
// Number of storage entries in the timestamp FIFO
`define TSR_FIFO_DEPTH 8
// Reset value of both counter halves
`define TSR_CNT_RST 32'h0000_0000
// One count of the counter halves
`define TSR_CNT_STEP 32'h0000_0001

`endif

// ---- hdl/tsr_pkg.sv ----
`include "tsr_defines.svh"

package tsr_pkg;

	// One captured word: upper half first, so hi lands in bits 63:32
	typedef struct packed {
		logic [`TSR_HALF_W-1:0] hi;
		logic [`TSR_HALF_W-1:0] lo;
	} tsr_word_t;

	// State of the recorder top outside the FIFO
	typedef struct packed {
		tsr_word_t cnt;
		logic ref_q;
		logic trig_q;
		logic overflow;
	} tsr_state_t;

endpackage

// ---- hdl/tsr_recorder.sv ----
`timescale 1ns/1ps
`include "tsr_defines.svh"

module tsr_fifo #(
	parameter int W = `TSR_WORD_W,
	parameter int DEPTH = `TSR_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic ov;
		logic [W-1:0] od;
	} tsr_fifo_state_t;

	tsr_fifo_state_t s;
	tsr_fifo_state_t next_s;
	logic push;
	logic load;

	// Output stage is a register so the head word never comes through a mux
	assign out_valid = s.ov;
	assign out_data = s.od;
	// Storage full stalls the writer even when the head is being drained
	assign in_ready = (s.count != FULL);
	assign push = in_valid && in_ready;
	assign load = (!s.ov || out_ready) && (s.count != '0);

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr_ptr] = in_data;
			next_s.wr_ptr = (s.wr_ptr == LAST) ? '0 : PW'(s.wr_ptr + 1'b1);
		end
		if (s.ov && out_ready) begin
			next_s.ov = 1'b0;
		end
		if (load) begin
			next_s.od = s.mem[s.rd_ptr];
			next_s.ov = 1'b1;
			next_s.rd_ptr = (s.rd_ptr == LAST) ? '0 : PW'(s.rd_ptr + 1'b1);
		end
		if (push && !load) begin
			next_s.count = CW'(s.count + 1'b1);
		end else if (load && !push) begin
			next_s.count = CW'(s.count - 1'b1);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

module tsr_recorder #(
	parameter int DEPTH = `TSR_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ts_reset,
	input wire logic sync_mode,
	input wire logic seconds_ref,
	input wire logic trigger,
	input wire logic ovf_clear,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [`TSR_WORD_W-1:0] rd_data,
	output logic overflow
);

	tsr_pkg::tsr_state_t s;
	tsr_pkg::tsr_state_t next_s;
	logic trig_rise;
	logic ref_rise;
	logic fifo_ready;
	logic [`TSR_WORD_W-1:0] capture;

	// Trigger is held for at least two clocks; the edge is found against trig_q, so one edge gives one capture
	assign trig_rise = trigger && !s.trig_q;
	assign ref_rise = seconds_ref && !s.ref_q;
	assign capture = s.cnt;
	assign overflow = s.overflow;

	always_comb begin
		next_s = s;
		next_s.trig_q = trigger;
		next_s.ref_q = seconds_ref;
		if (ts_reset) begin
			next_s.cnt.hi = `TSR_CNT_RST;
			next_s.cnt.lo = `TSR_CNT_RST;
		end else if (sync_mode) begin
			// Seconds in hi, sample position inside the second in lo
			if (ref_rise) begin
				next_s.cnt.lo = `TSR_CNT_RST;
				next_s.cnt.hi = s.cnt.hi + `TSR_CNT_STEP;
			end else begin
				next_s.cnt.lo = s.cnt.lo + `TSR_CNT_STEP;
			end
		end else begin
			next_s.cnt = `TSR_WORD_W'(s.cnt + 1'b1);
		end
		// A capture that finds the FIFO full is dropped and remembered
		if (trig_rise && !fifo_ready) begin
			next_s.overflow = 1'b1;
		end else if (ovf_clear) begin
			next_s.overflow = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Host side drains on its own handshake, unrelated to triggering
	tsr_fifo #(
		.W(`TSR_WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.rstn(rstn),
		.in_valid(trig_rise),
		.in_ready(fifo_ready),
		.in_data(capture),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	property p_reset_clears;
		@(posedge clock) disable iff (!rstn)
		ts_reset |=> (s.cnt == '0);
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("counter not zero after reset command");

	property p_free_advance;
		@(posedge clock) disable iff (!rstn)
		(!ts_reset && !sync_mode) |=> (s.cnt == `TSR_WORD_W'($past(s.cnt) + 1'b1));
	endproperty
	a_free_advance: assert property (p_free_advance)
		else $error("free counter did not advance by one");

	property p_no_spurious_push;
		@(posedge clock) disable iff (!rstn)
		!trig_rise |=> $stable(u_fifo.s.wr_ptr);
	endproperty
	a_no_spurious_push: assert property (p_no_spurious_push)
		else $error("storage written without a trigger edge");

	property p_push_when_room;
		@(posedge clock) disable iff (!rstn)
		(trig_rise && fifo_ready && !rd_valid && (u_fifo.s.count == '0))
			|=> ##1 (rd_valid && rd_data == $past(capture, 2));
	endproperty
	a_push_when_room: assert property (p_push_when_room)
		else $error("captured word did not reach the output");

	property p_read_hold;
		@(posedge clock) disable iff (!rstn)
		(rd_valid && !rd_ready) |=> (rd_valid && $stable(rd_data));
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("unread head word changed or vanished");

	property p_read_next;
		@(posedge clock) disable iff (!rstn)
		(rd_valid && rd_ready && (u_fifo.s.count == '0)) |=> !rd_valid;
	endproperty
	a_read_next: assert property (p_read_next)
		else $error("popped head word still shown with storage empty");

	property p_unread_flag;
		@(posedge clock) disable iff (!rstn)
		(u_fifo.s.count != '0) |=> rd_valid;
	endproperty
	a_unread_flag: assert property (p_unread_flag)
		else $error("stored entries not flagged as unread");

	property p_sub_clear;
		@(posedge clock) disable iff (!rstn)
		(sync_mode && ref_rise && !ts_reset) |=> (s.cnt.lo == '0);
	endproperty
	a_sub_clear: assert property (p_sub_clear)
		else $error("sub-second count not cleared on reference edge");

	property p_sec_step;
		@(posedge clock) disable iff (!rstn)
		(sync_mode && ref_rise && !ts_reset)
			|=> (s.cnt.hi == `TSR_HALF_W'($past(s.cnt.hi) + 1'b1));
	endproperty
	a_sec_step: assert property (p_sec_step)
		else $error("seconds count did not step on reference edge");

	property p_sec_hold;
		@(posedge clock) disable iff (!rstn)
		(sync_mode && !ref_rise && !ts_reset)
			|=> (s.cnt.hi == $past(s.cnt.hi))
			&& (s.cnt.lo == `TSR_HALF_W'($past(s.cnt.lo) + 1'b1));
	endproperty
	a_sec_hold: assert property (p_sec_hold)
		else $error("synced halves did not behave as separate parts");

	property p_no_carry_sync;
		@(posedge clock) disable iff (!rstn)
		(sync_mode && !ts_reset && !ref_rise && (s.cnt.lo == '1))
			|=> (s.cnt.lo == '0) && $stable(s.cnt.hi);
	endproperty
	a_no_carry_sync: assert property (p_no_carry_sync)
		else $error("sub-second wrap carried into seconds");

	property p_layout;
		@(posedge clock) disable iff (!rstn)
		(trig_rise && fifo_ready)
			|=> (u_fifo.s.mem[$past(u_fifo.s.wr_ptr)] == {$past(s.cnt.hi), $past(s.cnt.lo)});
	endproperty
	a_layout: assert property (p_layout)
		else $error("seconds not in upper half of captured word");

	property p_overflow_set;
		@(posedge clock) disable iff (!rstn)
		(trig_rise && !fifo_ready) |=> overflow;
	endproperty
	a_overflow_set: assert property (p_overflow_set)
		else $error("overflow not flagged on full capture");

	property p_overflow_sticky;
		@(posedge clock) disable iff (!rstn)
		(overflow && !ovf_clear) |=> overflow;
	endproperty
	a_overflow_sticky: assert property (p_overflow_sticky)
		else $error("overflow dropped without clear");

	property p_ovf_clear;
		@(posedge clock) disable iff (!rstn)
		(ovf_clear && !(trig_rise && !fifo_ready)) |=> !overflow;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear)
		else $error("overflow not cleared by clear request");

	property p_cov_capture;
		@(posedge clock) disable iff (!rstn)
		trig_rise && fifo_ready;
	endproperty
	c_cov_capture: cover property (p_cov_capture);

	property p_cov_overflow;
		@(posedge clock) disable iff (!rstn)
		trig_rise && !fifo_ready;
	endproperty
	c_cov_overflow: cover property (p_cov_overflow);

	property p_cov_second;
		@(posedge clock) disable iff (!rstn)
		sync_mode && ref_rise ##1 trig_rise;
	endproperty
	c_cov_second: cover property (p_cov_second);

	property p_cov_read;
		@(posedge clock) disable iff (!rstn)
		rd_valid && rd_ready && trig_rise;
	endproperty
	c_cov_read: cover property (p_cov_read);

	property p_cov_reset_capture;
		@(posedge clock) disable iff (!rstn)
		trig_rise && ts_reset;
	endproperty
	c_cov_reset_capture: cover property (p_cov_reset_capture);

endmodule

// ---- dv/tsr_host_model.sv ----
`timescale 1ns/1ps

// Host reader and seconds reference on the far side of the recorder
module tsr_host_model #(
	parameter int REF_PERIOD = 60
) (
	input wire logic clock,
	input wire logic stall,
	output logic rd_ready = 1'b0,
	output logic seconds_ref = 1'b0
);
	int phase = 0;

	// A short period stands in for one second so that several edges fit in the run
	always @(negedge clock) begin
		rd_ready <= !stall && ($urandom_range(1) == 1);
		phase <= (phase == REF_PERIOD - 1) ? 0 : phase + 1;
		seconds_ref <= (phase < 4);
	end
endmodule

// ---- dv/test_trigger_timestamp_recorder.sv ----
`timescale 1ns/1ps
`include "tsr_defines.svh"

module test_trigger_timestamp_recorder;
	localparam int DEPTH = 8;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic ts_reset = 1'b0;
	logic sync_mode = 1'b0;
	logic trigger = 1'b0;
	logic ovf_clear = 1'b0;
	logic stall = 1'b1;
	logic seconds_ref;
	logic rd_valid;
	logic rd_ready;
	logic overflow;
	logic [`TSR_WORD_W-1:0] rd_data;
	int n_errors = 0;
	int compares = 0;
	int seed_v;
	int q_used;
	tsr_pkg::tsr_word_t cnt;
	logic trig_prev;
	logic ref_prev;
	logic exp_ovf;
	logic [`TSR_WORD_W-1:0] exp_q[$];

	tsr_recorder #(.DEPTH(DEPTH)) u_tsr_recorder (.clock(clock), .rstn(rstn),
		.ts_reset(ts_reset), .sync_mode(sync_mode), .seconds_ref(seconds_ref),
		.trigger(trigger), .ovf_clear(ovf_clear), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .overflow(overflow));

	tsr_host_model u_tsr_host_model (.clock(clock), .stall(stall),
		.rd_ready(rd_ready), .seconds_ref(seconds_ref));

	initial begin
		forever #2 clock = ~clock;
	end

	function automatic tsr_pkg::tsr_word_t next_count(input tsr_pkg::tsr_word_t c,
			input logic clr, input logic sync, input logic ref_rise);
		next_count = c + 64'h1;
		if (sync) begin
			next_count.hi = ref_rise ? c.hi + 32'h1 : c.hi;
			next_count.lo = ref_rise ? 32'h0 : c.lo + 32'h1;
		end
		if (clr)
			next_count = 64'h0;
	endfunction

	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish;
		$display("Errors: %0d, comparisons: %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reads pre-edge values in the active region, before the design's updates land
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt = 64'h0;
			trig_prev = 1'b0;
			ref_prev = 1'b0;
			exp_ovf = 1'b0;
			exp_q.delete();
		end else begin
			// Room is judged before this edge's pop, as the storage count is
			q_used = exp_q.size();
			if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
				check(exp_q.size() > 0 && rd_data === exp_q[0], "timestamp differs");
				if (exp_q.size() > 0)
					exp_q.delete(0);
			end
			if (trigger && !trig_prev && q_used >= DEPTH + 1)
				exp_ovf = 1'b1;
			else if (ovf_clear)
				exp_ovf = 1'b0;
			if (trigger && !trig_prev && q_used < DEPTH + 1)
				exp_q.push_back(cnt);
			cnt = next_count(cnt, ts_reset, sync_mode, seconds_ref && !ref_prev);
			trig_prev = trigger;
			ref_prev = seconds_ref;
		end
	end

	// Trigger held two clocks as the input requires, then low for gap clocks
	task automatic pulse_trigger(input int gap, input logic clr);
		ts_reset = clr;
		trigger = 1'b1;
		@(negedge clock);
		ts_reset = 1'b0;
		@(negedge clock);
		trigger = 1'b0;
		repeat (gap) @(negedge clock);
	endtask

	initial begin
		seed_v = $urandom(32'h4c7a);
		repeat (5) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		stall = 1'b0;
		for (int i = 0; i < 80; i++) begin
			if (i == 40)
				sync_mode = 1'b1;
			pulse_trigger($urandom_range(6, 1), $urandom_range(7) == 0);
			check(overflow === exp_ovf, "overflow flag wrong");
		end
		// Reader stalled so storage fills; later triggers must be dropped
		stall = 1'b1;
		repeat (DEPTH + 3) pulse_trigger(1, 1'b0);
		repeat (3) @(negedge clock);
		check(overflow === 1'b1 && exp_ovf === 1'b1 && exp_q.size() == DEPTH + 1, "full not flagged");
		ovf_clear = 1'b1;
		@(negedge clock);
		ovf_clear = 1'b0;
		@(negedge clock);
		check(overflow === 1'b0 && exp_ovf === 1'b0, "overflow not cleared");
		stall = 1'b0;
		for (int t = 0; t < 300 && exp_q.size() != 0; t++)
			@(negedge clock);
		repeat (3) @(negedge clock);
		check(rd_valid === 1'b0 && exp_q.size() == 0, "entries left unread");
		tally_and_finish();
	end

	initial begin
		#(4 * 20000);
		n_errors++;
		$display("CHECK FAILED at %0t: run did not complete", $time);
		tally_and_finish();
	end
endmodule
